//--- logic/ppf_pkg.sv
// Shared constants for the pre-pit block formatter and its decoder
package ppf_pkg;
    localparam int FRAMES = 16;
    localparam int POS_BITS = 3;
    localparam logic [2:0] PAT_ONE = 3'h5;
    localparam logic [2:0] PAT_ZERO = 3'h4;
    localparam logic [2:0] PAT_SYNC = 3'h7;
    localparam int FRAME_BITS = 13;
    localparam logic [7:0] GF_POLY_LOW = 8'h1D;
    localparam logic [7:0] GEN_C2 = 8'h07;
    localparam logic [7:0] GEN_C1 = 8'h0E;
    localparam logic [7:0] GEN_C0 = 8'h08;
    localparam logic [7:0] TAG_ADDR = 8'h00;
    localparam logic [7:0] TAG_MAX = 8'h05;
    localparam logic [19:0] LEADIN_CYCLE_START = 20'h024FA;
    localparam logic [19:0] LEADIN_LAST0 = 20'h02FFE;
    localparam logic [19:0] DATA_ZONE_START = 20'h03000;
    localparam logic [23:0] DATA_ZONE_PSN = 24'h030000;
    localparam logic [3:0] IDX_PAR_A = 4'h3;
    localparam logic [3:0] IDX_TAG = 4'h6;
    localparam logic [3:0] IDX_PAR_B = 4'hD;

    typedef enum logic [2:0] {
        PPF_IDLE = 3'b001,
        PPF_SEND = 3'b010,
        PPF_DONE = 3'b100
    } ppf_state_e;

    // GF(256) multiply with the field polynomial
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = x[7] ? ({x[6:0], 1'b0} ^ GF_POLY_LOW) : {x[6:0], 1'b0};
        end
        return p;
    endfunction

    // One LFSR step of division by the three-root generator
    function automatic logic [23:0] rs_step(input logic [23:0] r, input logic [7:0] d);
        logic [7:0] fb;
        fb = d ^ r[23:16];
        return {r[15:8] ^ gf_mul(fb, GEN_C2), r[7:0] ^ gf_mul(fb, GEN_C1), gf_mul(fb, GEN_C0)};
    endfunction
endpackage

//--- logic/ppf_link_if.sv
// Serial pre-pit link between formatter and decoder
interface ppf_link_if;
    logic pit;
    logic pit_valid;
    logic frame_start;
    modport enc (output pit, output pit_valid, output frame_start);
    modport dec (input pit, input pit_valid, input frame_start);
endinterface

//--- logic/ppf_encoder.sv
// Pre-pit block formatter: builds 16-frame blocks and sends them as pit patterns
// How it works
// - Part A address, part B tagged info
// - Class tag zero to five only
// - Lead-in cycles classes, last two zero
// - Sixteen frames, four-bit index per frame
// - Index equals sector number low bits
// - Index sent raw without coding
// - Address is sector number bits 23:4
// - Data zone starts at address 3000
// - Parity A over address bytes
// - Parity B over bytes six to twelve
// - Generator roots alpha zero one two
// - Sync, index, then data byte msb first
// - Class zero repeats address, reserved zero
// - Receiver classifies blocks and flags bad ones
// - One is 101, zero is 100
module ppf_encoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Block request
    input wire logic start,
    input wire logic [23:0] sector_num,
    input wire logic [2:0] lead_class,
    input wire logic [55:0] class_info,
    output logic busy,
    output logic block_done,
    // Link
    ppf_link_if.enc link
);
    ppf_pkg::ppf_state_e state_ff;
    logic [7:0] bytes_ff [ppf_pkg::FRAMES];
    logic [3:0] frame_ff;
    logic [3:0] bit_ff;
    logic [1:0] pos_ff;
    logic [23:0] par_a;
    logic [23:0] par_b;
    logic [19:0] addr;
    logic [7:0] tag;
    logic [12:0] frame_word;
    logic [2:0] pattern;
    logic last_pos;

    assign addr = sector_num[23:4];

    always_comb begin
        logic [19:0] off;
        off = addr - ppf_pkg::LEADIN_CYCLE_START;
        tag = ppf_pkg::TAG_ADDR;
        // Lead-in classes cycle from the window start
        if (addr >= ppf_pkg::LEADIN_CYCLE_START && addr < ppf_pkg::LEADIN_LAST0 && lead_class != 3'h0) begin
            tag = 8'((off % 20'(ppf_pkg::TAG_MAX)) + 20'h00001);
        end
    end

    always_comb begin
        par_a = 24'h000000;
        par_a = ppf_pkg::rs_step(par_a, addr[19:16] == 4'h0 ? 8'h00 : {4'h0, addr[19:16]});
        par_a = ppf_pkg::rs_step(par_a, addr[15:8]);
        par_a = ppf_pkg::rs_step(par_a, addr[7:0]);
    end

    always_comb begin
        logic [55:0] info;
        info = 56'h0;
        if (tag == ppf_pkg::TAG_ADDR) begin
            info = {tag, 4'h0, addr, 24'h000000};
        end else begin
            info = {tag, class_info[47:0]};
        end
        par_b = 24'h000000;
        for (int i = 6; i >= 0; i--) begin
            par_b = ppf_pkg::rs_step(par_b, info[i*8 +: 8]);
        end
    end

    // Block load and frame stepping
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ppf_pkg::PPF_IDLE;
            frame_ff <= 4'h0;
            bit_ff <= 4'h0;
            pos_ff <= 2'h0;
            for (int i = 0; i < ppf_pkg::FRAMES; i++) begin
                bytes_ff[i] <= 8'h00;
            end
        end else begin
            unique case (state_ff)
                ppf_pkg::PPF_IDLE: begin
                    if (start) begin
                        bytes_ff[0] <= {4'h0, addr[19:16]};
                        bytes_ff[1] <= addr[15:8];
                        bytes_ff[2] <= addr[7:0];
                        bytes_ff[3] <= par_a[23:16];
                        bytes_ff[4] <= par_a[15:8];
                        bytes_ff[5] <= par_a[7:0];
                        bytes_ff[6] <= tag;
                        for (int i = 0; i < 6; i++) begin
                            bytes_ff[7 + i] <= (tag == ppf_pkg::TAG_ADDR)
                                ? ((i < 3) ? bytes_ff_init(addr, i) : 8'h00)
                                : class_info[(5 - i)*8 +: 8];
                        end
                        bytes_ff[13] <= par_b[23:16];
                        bytes_ff[14] <= par_b[15:8];
                        bytes_ff[15] <= par_b[7:0];
                        // Start index at sector low bits
                        frame_ff <= sector_num[3:0];
                        bit_ff <= 4'h0;
                        pos_ff <= 2'h0;
                        state_ff <= ppf_pkg::PPF_SEND;
                    end
                end
                ppf_pkg::PPF_SEND: begin
                    if (last_pos) begin
                        pos_ff <= 2'h0;
                        if (bit_ff == 4'(ppf_pkg::FRAME_BITS - 1)) begin
                            bit_ff <= 4'h0;
                            frame_ff <= frame_ff + 4'h1;
                            if (frame_ff == 4'hF) begin
                                state_ff <= ppf_pkg::PPF_DONE;
                            end
                        end else begin
                            bit_ff <= bit_ff + 4'h1;
                        end
                    end else begin
                        pos_ff <= pos_ff + 2'h1;
                    end
                end
                ppf_pkg::PPF_DONE: begin
                    state_ff <= ppf_pkg::PPF_IDLE;
                end
                default: begin
                    state_ff <= ppf_pkg::PPF_IDLE;
                end
            endcase
        end
    end

    function automatic logic [7:0] bytes_ff_init(input logic [19:0] a, input int i);
        logic [23:0] w;
        w = {4'h0, a};
        return w[(2 - i)*8 +: 8];
    endfunction

    assign frame_word = {1'b1, frame_ff, bytes_ff[frame_ff]};
    assign pattern = (bit_ff == 4'h0) ? ppf_pkg::PAT_SYNC
        : (frame_word[4'(12) - bit_ff] ? ppf_pkg::PAT_ONE : ppf_pkg::PAT_ZERO);
    assign last_pos = (pos_ff == 2'(ppf_pkg::POS_BITS - 1));

    // Link outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            link.pit <= 1'b0;
            link.pit_valid <= 1'b0;
            link.frame_start <= 1'b0;
        end else begin
            link.pit <= (state_ff == ppf_pkg::PPF_SEND) && pattern[2'(2) - pos_ff];
            link.pit_valid <= (state_ff == ppf_pkg::PPF_SEND);
            link.frame_start <= (state_ff == ppf_pkg::PPF_SEND) && bit_ff == 4'h0 && pos_ff == 2'h0;
        end
    end

    assign busy = (state_ff != ppf_pkg::PPF_IDLE);
    assign block_done = (state_ff == ppf_pkg::PPF_DONE);
endmodule

//--- logic/ppf_decoder.sv
// Pre-pit block decoder: collects frames, checks parity and index order
module ppf_decoder (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link
    ppf_link_if.dec link,
    // Decoded block
    output logic blk_valid,
    output logic [19:0] blk_addr,
    output logic [7:0] block_class_tag,
    output logic [47:0] blk_info,
    output logic blk_error
);
    logic [12:0] shift_ff;
    logic [2:0] pat_ff;
    logic [1:0] pos_ff;
    logic [3:0] bits_ff;
    logic [3:0] exp_ff;
    logic [4:0] count_ff;
    logic seq_err_ff;
    logic [7:0] bytes_ff [ppf_pkg::FRAMES];
    logic [2:0] pat_now;
    logic frame_end;
    logic [23:0] syn_a;
    logic [23:0] syn_b;

    assign pat_now = {pat_ff[1:0], link.pit};
    assign frame_end = link.pit_valid && pos_ff == 2'h2 && bits_ff == 4'hC;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pat_ff <= 3'h0;
            pos_ff <= 2'h0;
            bits_ff <= 4'h0;
            shift_ff <= 13'h0000;
        end else if (link.pit_valid) begin
            pat_ff <= pat_now;
            if (link.frame_start) begin
                pos_ff <= 2'h1;
                bits_ff <= 4'h0;
                pat_ff <= {2'h0, link.pit};
            end else if (pos_ff == 2'h2) begin
                pos_ff <= 2'h0;
                bits_ff <= bits_ff + 4'h1;
                shift_ff <= {shift_ff[11:0], pat_now == ppf_pkg::PAT_ONE};
            end else begin
                pos_ff <= pos_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            exp_ff <= 4'h0;
            count_ff <= 5'h00;
            seq_err_ff <= 1'b0;
            for (int i = 0; i < ppf_pkg::FRAMES; i++) begin
                bytes_ff[i] <= 8'h00;
            end
        end else if (frame_end) begin
            bytes_ff[shift_ff[10:7]] <= {shift_ff[6:0], pat_now == ppf_pkg::PAT_ONE};
            exp_ff <= shift_ff[10:7] + 4'h1;
            if (count_ff == 5'h10 || shift_ff[10:7] == 4'h0) begin
                count_ff <= 5'h01;
                seq_err_ff <= (shift_ff[10:7] != 4'h0);
            end else begin
                count_ff <= count_ff + 5'h01;
                seq_err_ff <= seq_err_ff | (shift_ff[10:7] != exp_ff);
            end
        end else if (count_ff == 5'h10) begin
            count_ff <= 5'h00;
        end
    end

    always_comb begin
        syn_a = 24'h000000;
        for (int i = 0; i < 3; i++) begin
            syn_a = ppf_pkg::rs_step(syn_a, bytes_ff[i]);
        end
        syn_a = syn_a ^ {bytes_ff[3], bytes_ff[4], bytes_ff[5]};
        syn_b = 24'h000000;
        for (int i = 6; i < 13; i++) begin
            syn_b = ppf_pkg::rs_step(syn_b, bytes_ff[i]);
        end
        syn_b = syn_b ^ {bytes_ff[13], bytes_ff[14], bytes_ff[15]};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blk_valid <= 1'b0;
            blk_addr <= 20'h00000;
            block_class_tag <= 8'h00;
            blk_info <= 48'h0;
            blk_error <= 1'b0;
        end else begin
            blk_valid <= (count_ff == 5'h10) && !frame_end;
            if (count_ff == 5'h10 && !frame_end) begin
                blk_addr <= {bytes_ff[0][3:0], bytes_ff[1], bytes_ff[2]};
                block_class_tag <= bytes_ff[6];
                blk_info <= {bytes_ff[7], bytes_ff[8], bytes_ff[9], bytes_ff[10], bytes_ff[11], bytes_ff[12]};
                blk_error <= seq_err_ff || syn_a != 24'h000000 || syn_b != 24'h000000
                    || bytes_ff[6] > ppf_pkg::TAG_MAX;
            end
        end
    end
endmodule

//--- tb/ppf_checker_sva.sv
// Concurrent checks on the pre-pit link and the block handshakes
module ppf_checker_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link
    input wire logic pit,
    input wire logic pit_valid,
    input wire logic frame_start,
    // Block ends
    input wire logic start,
    input wire logic busy,
    input wire logic block_done,
    input wire logic blk_valid,
    input wire logic blk_error,
    input wire logic [7:0] block_class_tag
);
    logic [5:0] pos_ff;
    logic [5:0] cur_pos;
    logic [9:0] vcnt_ff;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Position of the current cycle within its frame
    assign cur_pos = frame_start ? 6'h00 : pos_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_ff <= 6'h00;
        end else begin
            pos_ff <= cur_pos + 6'h01;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vcnt_ff <= 10'h000;
        end else begin
            vcnt_ff <= pit_valid ? vcnt_ff + 10'h001 : 10'h000;
        end
    end
    AST_START_TO_LINK: assert property (start && !busy |-> ##2 (pit_valid && frame_start && pit))
        else $error("link did not open two cycles after start");
    AST_SYNC_CODE: assert property (frame_start |-> pit ##1 pit ##1 pit)
        else $error("sync code is not 111");
    AST_BIT_MARK: assert property (pit_valid && cur_pos > 6'h02 && cur_pos % 6'h03 == 6'h00 |-> pit ##1 !pit)
        else $error("data bit pattern does not start with 10");
    AST_FRAME_GAP: assert property (frame_start |-> ##39 (frame_start || !pit_valid))
        else $error("frame is not 39 positions long");
    AST_BLOCK_LEN: assert property ($fell(pit_valid) |-> vcnt_ff == 10'h270)
        else $error("block is not 16 frames long");
    AST_DONE_TIME: assert property (start && !busy |-> ##[625:625] block_done)
        else $error("block done at the wrong cycle");
    AST_DEC_SOON: assert property ($fell(pit_valid) |-> ##[0:3] blk_valid)
        else $error("decoder gave no block");
    AST_NO_ERR: assert property (blk_valid |-> !blk_error)
        else $error("looped block failed its check");
    AST_TAG_RANGE: assert property (blk_valid |-> block_class_tag <= 8'h05)
        else $error("class tag out of range");
    cover property (blk_valid && block_class_tag == 8'h05);
    cover property (start && busy);
    cover property ($fell(pit_valid));
endmodule

//--- tb/test_prepit_block_formatter.sv
// Loop-back and fault-injection bench for the pre-pit block formatter
module test_prepit_block_formatter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [23:0] sector_num = 24'h000000;
    logic [2:0] lead_class = 3'h0;
    logic [55:0] class_info = 56'h0;
    logic busy, block_done, blk_valid, blk_error, v2, e2, fs;
    logic [19:0] blk_addr, a2;
    logic [7:0] block_class_tag, t2;
    logic [47:0] blk_info, i2;
    logic [7:0] fr [16];
    int mismatches = 0;
    int n_tests = 0;
    ppf_link_if link ();
    ppf_link_if link2 ();
    always_comb fs = link.frame_start;
    ppf_encoder i_ppf_encoder (.clock(clock), .rst_n(rst_n), .start(start), .sector_num(sector_num),
        .lead_class(lead_class), .class_info(class_info), .busy(busy), .block_done(block_done), .link(link.enc));
    ppf_decoder i_ppf_decoder (.clock(clock), .rst_n(rst_n), .link(link.dec), .blk_valid(blk_valid),
        .blk_addr(blk_addr), .block_class_tag(block_class_tag), .blk_info(blk_info), .blk_error(blk_error));
    ppf_decoder i_ppf_decoder_2 (.clock(clock), .rst_n(rst_n), .link(link2.dec), .blk_valid(v2),
        .blk_addr(a2), .block_class_tag(t2), .blk_info(i2), .blk_error(e2));
    ppf_checker_sva i_ppf_checker_sva (.clock(clock), .rst_n(rst_n), .pit(link.pit), .pit_valid(link.pit_valid),
        .frame_start(link.frame_start), .start(start), .busy(busy), .block_done(block_done),
        .blk_valid(blk_valid), .blk_error(blk_error), .block_class_tag(block_class_tag));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Idle far-side line keeps changing while waiting
    task automatic await(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1) begin
            @(posedge clock);
            link2.pit <= ~link2.pit;
            #1;
            k++;
            if (k > 40) begin
                mismatches++;
                wrap_up();
            end
        end
    endtask
    function automatic logic [7:0] mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            p = {p[6:0], 1'b0} ^ (p[7] ? 8'h1D : 8'h00) ^ (b[i] ? a : 8'h00);
        end
        return p;
    endfunction
    task automatic par(input int lo, input int n);
        logic [7:0] r2, r1, r0, fb;
        r2 = 8'h00;
        r1 = 8'h00;
        r0 = 8'h00;
        for (int j = lo; j < lo + n; j++) begin
            fb = fr[j] ^ r2;
            r2 = r1 ^ mul(fb, 8'h07);
            r1 = r0 ^ mul(fb, 8'h06 ^ mul(8'h02, 8'h04));
            r0 = mul(fb, mul(8'h02, 8'h04));
        end
        fr[lo + n] = r2;
        fr[lo + n + 1] = r1;
        fr[lo + n + 2] = r0;
    endtask
    task automatic build(input logic [19:0] a, input logic [7:0] tag, input logic [47:0] inf);
        fr[0] = {4'h0, a[19:16]};
        fr[1] = a[15:8];
        fr[2] = a[7:0];
        fr[6] = tag;
        for (int j = 0; j < 6; j++) begin
            fr[7 + j] = (tag != 8'h00) ? inf[47 - 8 * j -: 8] : (j < 3) ? fr[j] : 8'h00;
        end
        par(0, 3);
        par(6, 7);
    endtask
    function automatic logic [79:0] dec_exp();
        return {4'h0, fr[0][3:0], fr[1], fr[2], fr[6], fr[7], fr[8], fr[9], fr[10], fr[11], fr[12]};
    endfunction
    task automatic run_enc(input string nm, input logic [23:0] s, input logic [2:0] c, input logic [7:0] tag);
        logic [2:0] pat;
        logic [12:0] w;
        logic [12:0] we;
        logic [47:0] inf;
        inf = {5'h00, c, 40'hA55A0FF096};
        build(s[23:4], tag, inf);
        @(posedge clock);
        sector_num <= s;
        lead_class <= c;
        class_info <= {8'h00, inf};
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        #1;
        await(fs);
        for (int f = 0; f < 16; f++) begin
            we = {1'b1, 4'(f), fr[f]};
            for (int b = 0; b < 13; b++) begin
                for (int q = 0; q < 3; q++) begin
                    pat[2 - q] = link.pit;
                    @(posedge clock);
                    start <= (f == 5 && b == 0 && q == 0);
                    #1;
                end
                w[12 - b] = pat[0];
                check(pat, (b == 0) ? 3'h7 : {2'h2, we[12 - b]});
            end
            check({w[11:8], w[7:0]}, {4'(f), fr[f]});
        end
        await(blk_valid);
        check({3'h0, blk_error, blk_addr, block_class_tag, blk_info}, dec_exp());
        $display("Test %s done, mismatches %0d", nm, mismatches);
    endtask
    task automatic send(input int bad);
        logic [12:0] w;
        for (int f = 0; f < 16; f++) begin
            w = {1'b1, 4'(f + (f == bad)), fr[f]};
            for (int b = 0; b < 13; b++) begin
                for (int q = 0; q < 3; q++) begin
                    @(posedge clock);
                    link2.pit_valid <= 1'b1;
                    link2.frame_start <= (b == 0 && q == 0);
                    link2.pit <= (b == 0 || q == 0) ? 1'b1 : (q == 2) & w[12 - b];
                end
            end
        end
        @(posedge clock);
        link2.pit_valid <= 1'b0;
        link2.frame_start <= 1'b0;
        link2.pit <= ~link2.pit;
        #1;
        await(v2);
    endtask
    initial begin
        link2.pit = 1'b0;
        link2.pit_valid = 1'b0;
        link2.frame_start = 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        run_enc("data_zone", 24'h030000, 3'h2, 8'h00);
        for (int c = 1; c < 6; c++) begin
            run_enc("lead_in", 24'h024FA0 + 24'(16 * (c - 1)), 3'(c), 8'(c));
        end
        run_enc("lead_in_tail", 24'h02FFE0, 3'h4, 8'h00);
        run_enc("lead_in_end", 24'h02FFF0, 3'h5, 8'h00);
        build(20'h1A2B3, 8'h00, 48'h0);
        send(16);
        check({3'h0, e2, a2, t2, i2}, dec_exp());
        send(9);
        check(e2, 1'b1);
        fr[14] = fr[14] ^ 8'h40;
        send(16);
        check(e2, 1'b1);
        $display("Test fault_blocks done, mismatches %0d", mismatches);
        wrap_up();
    end
endmodule
